// file: design/tbc_pkg.sv
// Constants, register map and field layout of the buffered compare/capture channel block.
package tbc_pkg;
  // ==========================================================================
  // Widths and sizes
  localparam int CNT_W = 16;
  localparam int NCH = 2;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int MASK_W = 8;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFF_CAPCTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CTRLB_CLR = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_CTRLB_SET = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_EVCTRL = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_WAVE = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_INTFLAG = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_WAVEFORM_MASK_REG = 8'h1c;
  localparam logic [ADDR_W-1:0] OFF_PER = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_CC0 = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_PATTB = 8'h2c;
  localparam logic [ADDR_W-1:0] OFF_CYCLE_LENGTH_BUFFER = 8'h30;
  localparam logic [ADDR_W-1:0] OFF_CCB0 = 8'h34;
  localparam logic [ADDR_W-1:0] OFF_STRIDE = 8'h04;

  // ==========================================================================
  // Field positions
  localparam int CAPEN_LSB = 0;
  localparam int LOCK_BIT = 1;
  localparam int CMD_LSB = 5;
  localparam int CMD_W = 3;
  localparam int EVIN_LSB = 0;
  localparam int EVINV_BIT = 2;
  localparam int ACT_LSB = 4;
  localparam int MINCAP_BIT = 6;
  localparam int MODE_LSB = 0;
  localparam int POL_LSB = 8;
  localparam int MF_LSB = 0;
  localparam int FAULT_BIT = 2;
  localparam int WAVEFORM_MASK_BUF_VALID_BIT = 0;
  localparam int CYCLE_LENGTH_BUF_VALID_BIT = 1;
  localparam int CAPTURE_BUFFER_VALID_LSB = 2;

  // ==========================================================================
  // Codes and reset values
  localparam logic [CMD_W-1:0] CMD_UPDATE = 3'h3;
  typedef enum logic [1:0] {
    WM_FREE = 2'h0,
    WM_MATCHPER = 2'h1,
    WM_SSPWM = 2'h2,
    WM_DSPWM = 2'h3
  } tbc_mode_t;
  typedef enum logic [1:0] {
    EA_CAPTURE = 2'h0,
    EA_PER_WIDTH = 2'h1,
    EA_WIDTH_PER = 2'h2,
    EA_RSVD = 2'h3
  } tbc_act_t;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_HALF = 16'h8000;
  localparam logic [CNT_W-1:0] PER_RST = 16'hffff;
  localparam logic [MASK_W-1:0] WAVEFORM_MASK_REG_RST = 8'h00;

  // ==========================================================================
  // Timing: register write synchronisation delay
  localparam int CLK_PERIOD_NS = 5;
  localparam int SYNC_NS = 10;
  localparam int SYNC_DLY = (SYNC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// file: design/tbc_core.sv
// Compare/capture channels with double buffering, input capture FIFO and pulse capture.
//
// Summary of operation
// - Dual-slope: polarity picks set/clear ramp.
// - Toggle modes start from polarity level.
// - Mask, cycle length, compares have valid-flagged buffers.
// - Unlocked valid buffer copies at update, flag clears.
// - Software update command ignores lock.
// - Lock set/clear bits toggle double buffering.
// - Toggle modes, down PWM: unlocked cycle buffer copies continuously.
// - Direct cycle/compare writes land after sync delay.
// - Unbuffered up-count: count over top forces wrap.
// - Up-counting and dual-slope PWM: buffered cycle length loads only at update.
// - Capture event stores counter as timestamp.
// - Capture buffer moves to empty/read compare register.
// - Capture buffer reads as zero.
// - Capture while buffer valid: drop, flag fault.
// - Pulse capture while match flag set: drop, fault.
// - Period/width capture on both edges, order selectable.
// - Event invert picks restart edge.
// - Pulse capture needs channel capture enable.
// - Up-count minimum capture skips zero.
// - Dual-slope small top: direction in timestamp MSB.
// - Dual-slope update at counter zero.
// - Single-slope update at wrap, overflow, retrigger.
`timescale 1ns/100ps
`default_nettype none
module tbc_core import tbc_pkg::*; (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Register port
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DATA_W-1:0] o_rdata,
  // Counter core
  input wire logic [CNT_W-1:0] i_count,
  input wire logic i_count_down,
  input wire logic i_wrap,
  // Event system capture inputs (asynchronous)
  input wire logic [NCH-1:0] i_cap_ev,
  // Outputs to counter, pins and request logic
  output logic [CNT_W-1:0] o_cycle_len,
  output logic [MASK_W-1:0] o_wave_mask,
  output logic o_wrap_req,
  output logic o_restart,
  output logic [NCH-1:0] o_wo,
  output logic [NCH-1:0] o_match_flag,
  output logic o_fault
);
  // ==========================================================================
  // Register state
  logic [NCH-1:0] cap_en_reg, ev_in_en_reg, pol_reg, mf_reg, wo_reg;
  logic lock_reg, ev_inv_reg, min_cap_reg, fault_reg, restart_reg;
  tbc_mode_t mode_reg;
  tbc_act_t act_reg;
  logic [CNT_W-1:0] per_reg, cycle_length_buffer_reg, cnt_prev_reg;
  logic cycle_length_buf_valid_reg, waveform_mask_buf_valid_reg;
  logic [MASK_W-1:0] waveform_mask_reg_reg, pattb_reg;
  logic [CNT_W-1:0] cc_reg [NCH];
  logic [CNT_W-1:0] ccb_reg [NCH];
  logic [NCH-1:0] capture_buffer_valid_reg, full_reg;
  logic [NCH-1:0] ev_s1_reg, ev_s2_reg, ev_s3_reg;
  logic [SYNC_DLY-1:0] sp_vld_reg;
  logic [ADDR_W-1:0] sp_addr_reg [SYNC_DLY];
  logic [CNT_W-1:0] sp_data_reg [SYNC_DLY];
  logic [DATA_W-1:0] rdata_reg;

  // ==========================================================================
  // Decode and shared conditions
  logic upd_cmd, dual, cnt_moved, hw_upd, copy_ok, per_cont, land_per, ppw_mode;
  logic lead, trail, min_block, top_hit, zero_hit, wr_wave, wr_flag, sync_wr;
  logic [CNT_W-1:0] top, ts;
  logic [NCH-1:0] rise, fall, cap_take, ppw_take, ppw_store, xfer, cmp_hit;
  logic [NCH-1:0] land_cc, cc_rd, wr_ccb, cc_hit;

  assign upd_cmd = i_wr && (i_addr == OFF_CTRLB_SET)
                   && (i_wdata[CMD_LSB +: CMD_W] == CMD_UPDATE);
  assign dual = (mode_reg == WM_DSPWM);
  assign cnt_moved = (i_count != cnt_prev_reg);
  assign zero_hit = cnt_moved && (i_count == CNT_ZERO);
  // Update point: zero for dual slope, counter wrap events otherwise.
  assign hw_upd = dual ? zero_hit : i_wrap;
  assign copy_ok = (hw_upd && !lock_reg) || upd_cmd;
  // Unlocked, toggle modes and down-counting PWM follow the buffer at once.
  assign per_cont = !lock_reg && ((mode_reg == WM_FREE) || (mode_reg == WM_MATCHPER)
                    || ((mode_reg == WM_SSPWM) && i_count_down));
  assign land_per = sp_vld_reg[SYNC_DLY-1] && (sp_addr_reg[SYNC_DLY-1] == OFF_PER);
  assign top = (mode_reg == WM_MATCHPER) ? cc_reg[0] : per_reg;
  assign top_hit = cnt_moved && (i_count == top);
  // Top is watched continuously while counting up, so a top lowered below the count wraps at once.
  assign o_wrap_req = !i_count_down && (i_count >= top);
  assign wr_wave = i_wr && (i_addr == OFF_WAVE);
  assign wr_flag = i_wr && (i_addr == OFF_INTFLAG);
  assign sync_wr = i_wr && ((i_addr == OFF_PER) || (i_addr == OFF_CC0)
                   || (i_addr == OFF_CC0 + OFF_STRIDE));
  // Timestamp; with a small top the MSB carries the ramp direction.
  assign ts = (dual && (per_reg < CNT_HALF)) ?
              {i_count_down, i_count[CNT_W-2:0]} : i_count;
  // Zero is not capturable in up-counting minimum mode.
  assign min_block = min_cap_reg && !i_count_down && (i_count == CNT_ZERO);
  assign ppw_mode = (act_reg == EA_PER_WIDTH) || (act_reg == EA_WIDTH_PER);
  assign rise = ev_s2_reg & ~ev_s3_reg;
  assign fall = ~ev_s2_reg & ev_s3_reg;
  // Restart edge of the measured signal on event input 1.
  assign lead = ev_in_en_reg[1] && (ev_inv_reg ? fall[1] : rise[1]);
  assign trail = ev_in_en_reg[1] && (ev_inv_reg ? rise[1] : fall[1]);

  // ==========================================================================
  // Per-channel decode
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_dec
      assign cc_hit[g] = (i_addr == OFF_CC0 + ADDR_W'(g) * OFF_STRIDE);
      assign land_cc[g] = sp_vld_reg[SYNC_DLY-1]
                          && (sp_addr_reg[SYNC_DLY-1] == OFF_CC0 + ADDR_W'(g) * OFF_STRIDE);
      assign cc_rd[g] = i_rd && cc_hit[g];
      assign wr_ccb[g] = i_wr && (i_addr == OFF_CCB0 + ADDR_W'(g) * OFF_STRIDE);
      // Plain capture needs event input and capture enabled by software.
      assign cap_take[g] = !ppw_mode && ev_in_en_reg[g] && cap_en_reg[g]
                           && rise[g] && !min_block;
      // Period goes to channel 0 in period-then-width, to channel 1 otherwise.
      assign ppw_take[g] = ppw_mode && cap_en_reg[g]
                           && ((g == 0) == (act_reg == EA_PER_WIDTH) ? lead : trail);
      assign ppw_store[g] = ppw_take[g] && !mf_reg[g];
      assign xfer[g] = cap_en_reg[g] && capture_buffer_valid_reg[g] && (!full_reg[g] || cc_rd[g]);
      assign cmp_hit[g] = !cap_en_reg[g] && cnt_moved && (i_count == cc_reg[g]);
    end
  endgenerate

  // ==========================================================================
  // Input synchronisers and edge history for event inputs.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ev_s1_reg <= '0;
      ev_s2_reg <= '0;
      ev_s3_reg <= '0;
      cnt_prev_reg <= CNT_ZERO;
    end else begin
      ev_s1_reg <= i_cap_ev;
      ev_s2_reg <= ev_s1_reg;
      ev_s3_reg <= ev_s2_reg;
      cnt_prev_reg <= i_count;
    end
  end

  // Control registers; lock has separate set and clear strobes.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cap_en_reg <= '0;
      lock_reg <= 1'b0;
      ev_in_en_reg <= '0;
      ev_inv_reg <= 1'b0;
      act_reg <= EA_CAPTURE;
      min_cap_reg <= 1'b0;
      mode_reg <= WM_FREE;
      pol_reg <= '0;
    end else if (i_wr) begin
      if (i_addr == OFF_CAPCTRL) begin
        cap_en_reg <= i_wdata[CAPEN_LSB +: NCH];
      end
      if ((i_addr == OFF_CTRLB_SET) && i_wdata[LOCK_BIT]) begin
        lock_reg <= 1'b1;
      end
      if ((i_addr == OFF_CTRLB_CLR) && i_wdata[LOCK_BIT]) begin
        lock_reg <= 1'b0;
      end
      if (i_addr == OFF_EVCTRL) begin
        ev_in_en_reg <= i_wdata[EVIN_LSB +: NCH];
        ev_inv_reg <= i_wdata[EVINV_BIT];
        act_reg <= tbc_act_t'(i_wdata[ACT_LSB +: 2]);
        min_cap_reg <= i_wdata[MINCAP_BIT];
      end
      if (wr_wave) begin
        mode_reg <= tbc_mode_t'(i_wdata[MODE_LSB +: 2]);
        pol_reg <= i_wdata[POL_LSB +: NCH];
      end
    end
  end

  // Direct period/compare writes travel a short pipe to model the sync delay.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sp_vld_reg <= '0;
      for (int k = 0; k < SYNC_DLY; k++) begin
        sp_addr_reg[k] <= '0;
        sp_data_reg[k] <= CNT_ZERO;
      end
    end else begin
      sp_vld_reg[0] <= sync_wr;
      sp_addr_reg[0] <= i_addr;
      sp_data_reg[0] <= i_wdata[CNT_W-1:0];
      for (int k = 1; k < SYNC_DLY; k++) begin
        sp_vld_reg[k] <= sp_vld_reg[k-1];
        sp_addr_reg[k] <= sp_addr_reg[k-1];
        sp_data_reg[k] <= sp_data_reg[k-1];
      end
    end
  end

  // Cycle length and its buffer; a buffer write wins over the copy's clear.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      per_reg <= PER_RST;
      cycle_length_buffer_reg <= PER_RST;
      cycle_length_buf_valid_reg <= 1'b0;
    end else begin
      if (land_per) begin
        per_reg <= sp_data_reg[SYNC_DLY-1];
      end else if (cycle_length_buf_valid_reg && (per_cont || copy_ok)) begin
        per_reg <= cycle_length_buffer_reg;
      end
      if (i_wr && (i_addr == OFF_CYCLE_LENGTH_BUFFER)) begin
        cycle_length_buffer_reg <= i_wdata[CNT_W-1:0];
        cycle_length_buf_valid_reg <= 1'b1;
      end else if (!land_per && cycle_length_buf_valid_reg && (per_cont || copy_ok)) begin
        cycle_length_buf_valid_reg <= 1'b0;
      end
    end
  end

  // Waveform mask and its buffer; no sync pipe, it only gates pins.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      waveform_mask_reg_reg <= WAVEFORM_MASK_REG_RST;
      pattb_reg <= WAVEFORM_MASK_REG_RST;
      waveform_mask_buf_valid_reg <= 1'b0;
    end else begin
      if (i_wr && (i_addr == OFF_WAVEFORM_MASK_REG)) begin
        waveform_mask_reg_reg <= i_wdata[MASK_W-1:0];
      end else if (waveform_mask_buf_valid_reg && copy_ok) begin
        waveform_mask_reg_reg <= pattb_reg;
      end
      if (i_wr && (i_addr == OFF_PATTB)) begin
        pattb_reg <= i_wdata[MASK_W-1:0];
        waveform_mask_buf_valid_reg <= 1'b1;
      end else if (waveform_mask_buf_valid_reg && copy_ok) begin
        waveform_mask_buf_valid_reg <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Channel storage, flags and waveform outputs.
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      // Compare: double buffer. Capture: buffer then compare register as a FIFO.
      always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          cc_reg[g] <= CNT_ZERO;
          ccb_reg[g] <= CNT_ZERO;
          capture_buffer_valid_reg[g] <= 1'b0;
          full_reg[g] <= 1'b0;
        end else if (!cap_en_reg[g]) begin
          full_reg[g] <= 1'b0;
          if (land_cc[g]) begin
            cc_reg[g] <= sp_data_reg[SYNC_DLY-1];
          end else if (capture_buffer_valid_reg[g] && copy_ok) begin
            cc_reg[g] <= ccb_reg[g];
          end
          if (wr_ccb[g]) begin
            ccb_reg[g] <= i_wdata[CNT_W-1:0];
            capture_buffer_valid_reg[g] <= 1'b1;
          end else if (!land_cc[g] && capture_buffer_valid_reg[g] && copy_ok) begin
            capture_buffer_valid_reg[g] <= 1'b0;
          end
        end else begin
          if (ppw_store[g]) begin
            cc_reg[g] <= ts;
            full_reg[g] <= 1'b1;
          end else if (xfer[g]) begin
            cc_reg[g] <= ccb_reg[g];
            full_reg[g] <= 1'b1;
          end else if (cc_rd[g]) begin
            full_reg[g] <= 1'b0;
          end
          // Buffer is written only while empty, so store and transfer never meet.
          if (cap_take[g] && !capture_buffer_valid_reg[g]) begin
            ccb_reg[g] <= ts;
            capture_buffer_valid_reg[g] <= 1'b1;
          end else if (xfer[g]) begin
            capture_buffer_valid_reg[g] <= 1'b0;
          end
        end
      end

      // Match flag: hardware set beats a software clear in the same cycle.
      always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          mf_reg[g] <= 1'b0;
        end else if (cmp_hit[g] || xfer[g] || ppw_store[g]) begin
          mf_reg[g] <= 1'b1;
        end else if (wr_flag && i_wdata[MF_LSB + g]) begin
          mf_reg[g] <= 1'b0;
        end
      end

      // Waveform output per mode, direction and polarity.
      always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          wo_reg[g] <= 1'b0;
        end else if (wr_wave) begin
          wo_reg[g] <= i_wdata[POL_LSB + g];
        end else begin
          unique case (mode_reg)
            WM_FREE: begin
              if (cmp_hit[g]) wo_reg[g] <= ~wo_reg[g];
            end
            WM_MATCHPER: begin
              if ((g == 0) ? top_hit : cmp_hit[g]) wo_reg[g] <= ~wo_reg[g];
            end
            WM_SSPWM: begin
              if (!i_count_down) begin
                if (pol_reg[g] ? cmp_hit[g] : top_hit) wo_reg[g] <= 1'b1;
                else if (pol_reg[g] ? top_hit : cmp_hit[g]) wo_reg[g] <= 1'b0;
              end else begin
                if (pol_reg[g] ? zero_hit : cmp_hit[g]) wo_reg[g] <= 1'b1;
                else if (pol_reg[g] ? cmp_hit[g] : zero_hit) wo_reg[g] <= 1'b0;
              end
            end
            WM_DSPWM: begin
              if (cmp_hit[g]) wo_reg[g] <= (i_count_down == pol_reg[g]);
            end
          endcase
        end
      end
    end
  endgenerate

  // Fault flag: buffer overflow or pulse capture over a pending match.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      fault_reg <= 1'b0;
    end else if (|(cap_take & capture_buffer_valid_reg) || |(ppw_take & mf_reg)) begin
      fault_reg <= 1'b1;
    end else if (wr_flag && i_wdata[FAULT_BIT]) begin
      fault_reg <= 1'b0;
    end
  end

  // Counter restart pulse on the lead edge in pulse capture.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      restart_reg <= 1'b0;
    end else begin
      restart_reg <= ppw_mode && lead;
    end
  end

  // Read data, registered on the strobe and held until the next read.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_reg <= '0;
    end else if (i_rd) begin
      rdata_reg <= '0;
      unique case (i_addr)
        OFF_CAPCTRL: rdata_reg[CAPEN_LSB +: NCH] <= cap_en_reg;
        OFF_CTRLB_CLR, OFF_CTRLB_SET: rdata_reg[LOCK_BIT] <= lock_reg;
        OFF_EVCTRL: begin
          rdata_reg[EVIN_LSB +: NCH] <= ev_in_en_reg;
          rdata_reg[EVINV_BIT] <= ev_inv_reg;
          rdata_reg[ACT_LSB +: 2] <= act_reg;
          rdata_reg[MINCAP_BIT] <= min_cap_reg;
        end
        OFF_WAVE: begin
          rdata_reg[MODE_LSB +: 2] <= mode_reg;
          rdata_reg[POL_LSB +: NCH] <= pol_reg;
        end
        OFF_INTFLAG: begin
          rdata_reg[MF_LSB +: NCH] <= mf_reg;
          rdata_reg[FAULT_BIT] <= fault_reg;
        end
        OFF_STATUS: begin
          rdata_reg[WAVEFORM_MASK_BUF_VALID_BIT] <= waveform_mask_buf_valid_reg;
          rdata_reg[CYCLE_LENGTH_BUF_VALID_BIT] <= cycle_length_buf_valid_reg;
          rdata_reg[CAPTURE_BUFFER_VALID_LSB +: NCH] <= capture_buffer_valid_reg;
        end
        OFF_WAVEFORM_MASK_REG: rdata_reg[MASK_W-1:0] <= waveform_mask_reg_reg;
        OFF_PATTB: rdata_reg[MASK_W-1:0] <= pattb_reg;
        OFF_PER: rdata_reg[CNT_W-1:0] <= per_reg;
        OFF_CYCLE_LENGTH_BUFFER: rdata_reg[CNT_W-1:0] <= cycle_length_buffer_reg;
        OFF_CC0: rdata_reg[CNT_W-1:0] <= cc_reg[0];
        OFF_CC0 + OFF_STRIDE: rdata_reg[CNT_W-1:0] <= cc_reg[1];
        default: rdata_reg <= '0;  // Capture buffers and holes read zero.
      endcase
    end
  end

  assign o_rdata = rdata_reg;
  assign o_cycle_len = per_reg;
  assign o_wave_mask = waveform_mask_reg_reg;
  assign o_restart = restart_reg;
  assign o_wo = wo_reg;
  assign o_match_flag = mf_reg;
  assign o_fault = fault_reg;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  sequence s_per_write;
    i_wr && (i_addr == OFF_PER);
  endsequence
  sequence s_pwp_lead;
    ppw_mode && (act_reg == EA_WIDTH_PER) && lead && cap_en_reg[1] && !mf_reg[1];
  endsequence

  ovf_fault_a: assert property (cap_take[0] && capture_buffer_valid_reg[0] |=> o_fault)
    else $error("capture overflow did not raise fault");
  buf_xfer_a: assert property (xfer[0] |=> (cc_reg[0] == $past(ccb_reg[0])) && o_match_flag[0])
    else $error("capture buffer not moved into compare register");
  lock_hold_a: assert property (cycle_length_buf_valid_reg && lock_reg && !upd_cmd && !land_per
                                |=> $stable(per_reg) && cycle_length_buf_valid_reg)
    else $error("locked cycle length buffer was copied");
  cmd_copy_a: assert property (upd_cmd && cycle_length_buf_valid_reg && !land_per
                               |=> (per_reg == $past(cycle_length_buffer_reg)) && !cycle_length_buf_valid_reg)
    else $error("update command did not copy cycle length");
  sync_land_a: assert property (s_per_write
                                |-> ##3 (o_cycle_len == $past(i_wdata[CNT_W-1:0], 3)))
    else $error("cycle length write did not land after sync delay");
  restart_edge_a: assert property (ppw_mode && ev_in_en_reg[1] && ev_inv_reg
                                   && !ev_s2_reg[1] && ev_s3_reg[1] |=> o_restart)
    else $error("restart missing on inverted falling edge");
  pwp_swap_a: assert property (s_pwp_lead |=> (cc_reg[1] == $past(ts)) && o_match_flag[1])
    else $error("width-then-period did not put period in channel one");
  cap_gate_a: assert property (!cap_en_reg[0] && !land_cc[0] && !(capture_buffer_valid_reg[0] && copy_ok)
                               |=> $stable(cc_reg[0]))
    else $error("compare channel changed by a capture");
  ds_msb_a: assert property (cap_take[0] && !capture_buffer_valid_reg[0] && dual && (per_reg < CNT_HALF)
                             |=> ccb_reg[0][CNT_W-1] == $past(i_count_down))
    else $error("timestamp MSB does not show ramp direction");
  min_cap_a: assert property (min_block && cap_en_reg[0] && !ppw_mode
                              && !capture_buffer_valid_reg[0] |=> !capture_buffer_valid_reg[0])
    else $error("zero captured in up-counting minimum mode");
  ds_pol_a: assert property (dual && cmp_hit[0] && !i_count_down && !pol_reg[0] && !wr_wave
                             |=> o_wo[0])
    else $error("dual-slope rising match did not set output");
endmodule
`default_nettype wire

// file: testbench/tbc_cnt_model.sv
// Counter core stand-in that feeds count and wrap pulses to the channel block.
`timescale 1ns/100ps
`default_nettype none
module tbc_cnt_model import tbc_pkg::*; (
  // Clock, reset and control
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_run,
  input wire logic i_restart,
  input wire logic [CNT_W-1:0] i_top,
  // Counter outputs
  output logic [CNT_W-1:0] o_count,
  output logic o_wrap
);
  // ==========================================================================
  // Up-counter that holds still when stopped unless restarted, so a captured value is known.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_count <= CNT_ZERO;
      o_wrap <= 1'b0;
    end else begin
      o_wrap <= i_run && (o_count >= i_top);
      if (i_restart || (i_run && (o_count >= i_top))) begin
        o_count <= CNT_ZERO;
      end else if (i_run) begin
        o_count <= o_count + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// file: testbench/timer_buffered_compare_capture_tb_top.sv
// Self-checking bench for the buffered compare/capture channel block.
`timescale 1ns/100ps
`default_nettype none
module timer_buffered_compare_capture_tb_top import tbc_pkg::*;;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic [ADDR_W-1:0] addr = 8'h00;
  logic [DATA_W-1:0] wdata = 32'h0, rdata, rv;
  logic wr = 1'b0, rd = 1'b0, run = 1'b0, cdown = 1'b0, restart, wrap, wreq, fault;
  logic [NCH-1:0] cap_ev = 2'h0, wo, mflag;
  logic [CNT_W-1:0] count, clen, ts;
  logic [MASK_W-1:0] wmask;
  int bad_count = 0;
  int comparisons = 0;
  // Rows: write address, write data, read address, expected read data.
  logic [39:0] rows [5] = '{40'h08_0002_08_02, 40'h30_0100_18_02, 40'h2c_005a_18_03,
    40'h34_0077_34_00, 40'h38_0066_18_0f};
  // ==========================================================================
  // Clock, design and counter model.
  always #2.5 i_clk = ~i_clk;
  tbc_core u_tbc_core (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_count(count), .i_count_down(cdown),
    .i_wrap(wrap), .i_cap_ev(cap_ev), .o_cycle_len(clen), .o_wave_mask(wmask),
    .o_wrap_req(wreq), .o_restart(restart), .o_wo(wo), .o_match_flag(mflag), .o_fault(fault));
  tbc_cnt_model u_tbc_cnt_model (.i_clk(i_clk), .i_rstn(i_rstn), .i_run(run),
    .i_restart(restart), .i_top(clen), .o_count(count), .o_wrap(wrap));
  // ==========================================================================
  // Tasks for comparisons, bus cycles and capture pulses.
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge i_clk);
    wr <= 1'b0;
  endtask
  // Read data are registered at the edge after the strobe and held, so sample just past that edge.
  task automatic rd_reg(input logic [7:0] a);
    @(posedge i_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_clk);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask
  task automatic pulse(input int ch);
    @(posedge i_clk);
    cap_ev[ch] <= 1'b1;
    repeat (3) @(posedge i_clk);
    cap_ev[ch] <= 1'b0;
    repeat (6) @(posedge i_clk);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ==========================================================================
  // Watchdog: the sequence needs well under a thousand cycles.
  initial begin
    #20000;
    bad_count++;
    give_verdict();
  end
  // ==========================================================================
  // Main sequence.
  initial begin
    repeat (20) @(posedge i_clk);
    chk("reset len", 32'h0000ffff, {16'h0, clen});
    chk("reset fault", 32'h0, {31'h0, fault});
    i_rstn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      wr_reg(rows[i][39:32], {16'h0, rows[i][31:16]});
      rd_reg(rows[i][15:8]);
      chk("row read", {24'h0, rows[i][7:0]}, rv);
    end
    $display("table done");
    wr_reg(OFF_CTRLB_SET, 32'h00000062);
    rd_reg(OFF_STATUS);
    chk("cmd status", 32'h0, rv);
    chk("cmd len", 32'h00000100, {16'h0, clen});
    chk("cmd mask", 32'h0000005a, {24'h0, wmask});
    rd_reg(OFF_CC0);
    chk("cmd cc0", 32'h00000077, rv);
    wr_reg(OFF_WAVE, 32'h00000300);
    #1 chk("wave init", 32'h3, {30'h0, wo});
    wr_reg(OFF_CTRLB_CLR, 32'h00000002);
    wr_reg(OFF_CYCLE_LENGTH_BUFFER, 32'h00000200);
    repeat (4) @(posedge i_clk);
    chk("free copy", 32'h00000200, {16'h0, clen});
    wr_reg(OFF_CTRLB_SET, 32'h00000002);
    wr_reg(OFF_PER, 32'h00000050);
    #1 chk("sync old", 32'h00000200, {16'h0, clen});
    repeat (4) @(posedge i_clk);
    #1 chk("sync new", 32'h00000050, {16'h0, clen});
    $display("buffer tests done");
    // Software enables capture first; the counter is halted so a timestamp is known.
    wr_reg(OFF_CAPCTRL, 32'h00000001);
    wr_reg(OFF_EVCTRL, 32'h00000001);
    run <= 1'b1;
    repeat (30) @(posedge i_clk);
    run <= 1'b0;
    @(posedge i_clk);
    #1 ts = count;
    pulse(0);
    chk("match set", 32'h1, {31'h0, mflag[0]});
    pulse(0);
    chk("no fault", 32'h0, {31'h0, fault});
    pulse(0);
    chk("overflow", 32'h1, {31'h0, fault});
    rd_reg(OFF_CC0);
    chk("stamp", {16'h0, ts}, rv);
    chk("no wrap req", 32'h0, {31'h0, wreq});
    wr_reg(OFF_PER, 32'h00000010);
    repeat (3) @(posedge i_clk);
    #1 chk("wrap req", 32'h1, {31'h0, wreq});
    $display("capture done");
    // Width-then-period on event input 1; the counter stays halted so stamps are known.
    wr_reg(OFF_CAPCTRL, 32'h00000003);
    wr_reg(OFF_EVCTRL, 32'h00000022);
    wr_reg(OFF_INTFLAG, 32'h00000007);
    rd_reg(OFF_INTFLAG);
    chk("flags clear", 32'h0, rv);
    pulse(1);
    chk("restart", 32'h0, {16'h0, count});
    rd_reg(OFF_CC0 + OFF_STRIDE);
    chk("period ch1", {16'h0, ts}, rv);
    rd_reg(OFF_CC0);
    chk("width ch0", 32'h0, rv);
    pulse(1);
    chk("ppw fault", 32'h1, {31'h0, fault});
    rd_reg(OFF_CC0 + OFF_STRIDE);
    chk("ppw kept", {16'h0, ts}, rv);
    $display("pulse capture done");
    // Dual slope, polarity 0: a match on the rising ramp sets, on the falling one clears.
    wr_reg(OFF_CAPCTRL, 32'h00000000);
    wr_reg(OFF_WAVE, 32'h00000003);
    run <= 1'b1;
    repeat (20) @(posedge i_clk);
    chk("ds rise", 32'h1, {31'h0, wo[0]});
    cdown <= 1'b1;
    repeat (20) @(posedge i_clk);
    chk("ds fall", 32'h0, {31'h0, wo[0]});
    run <= 1'b0;
    $display("dual slope done");
    give_verdict();
  end
endmodule
`default_nettype wire
